// file: src/ssrs_pkg.sv
// constants and carrier types for the sync signal routing select block
package ssrs_pkg;
    // bus geometry: register offsets are word indices, byte address is index times four
    localparam int          ADR_W          = 18;
    localparam logic [15:0] IDX_SEL        = 16'hfffe;
    localparam logic [15:0] IDX_MODE       = 16'hfffc;
    localparam logic [15:0] WIN_LO         = 16'hfff0;
    localparam logic [15:0] WIN_HI         = 16'hfff5;
    localparam logic [7:0]  SEL_RESET      = 8'h00;
    localparam logic [1:0]  MODE_RESET     = 2'h0;
    // field positions in timer_connection_select
    localparam int          BIT_TIMER_WIN  = 0;
    localparam int          BIT_ISGEN      = 1;
    localparam int          CLAMP_LO       = 2;
    localparam int          VERT_LO        = 4;
    localparam int          HORIZ_LO       = 6;
    // field position of the input sync mode in the mode register
    localparam int          MODE_LO        = 6;

    typedef enum logic [1:0] {
        SMODE_FEEDBACK  = 2'b00,
        SMODE_SONG      = 2'b01,
        SMODE_COMPOSITE = 2'b10,
        SMODE_SEPARATE  = 2'b11
    } ssrs_smode_t;

    // external sync pins, asynchronous to clock
    typedef struct packed {
        logic horiz_feedback_in;
        logic vert_feedback_in;
        logic composite_sync_in;
        logic horiz_sync_in;
        logic vert_sync_in;
        logic phase_detect_vert;
    } ssrs_pins_t;

    // on-chip sources, already on clock
    typedef struct packed {
        logic generated_horiz_sync;
        logic generated_vert_sync;
        logic clamp_wave_a;
        logic clamp_wave_b;
        logic clamp_wave_c;
        logic clamp_wave_d;
        logic clamp_derived_signal;
        logic fall_mod_strobe;
        logic mask_2fh;
    } ssrs_onchip_t;
endpackage

// file: src/ssrs_sync2.sv
// two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
module ssrs_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         resetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// file: src/ssrs_top.sv
// timer connection select register and sync signal routing
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// What this block does
// RULE1 - an 8-bit read/write selection register at index fffe resets to zero.
// RULE2 - the clamp selector codes 00 to 11 pick clamp waves a to d for the clamp output.
// RULE3 - with internal generation off the vertical selector picks one of four input versions.
// RULE4 - the versions are plain, aligned to horizontal, fall modified, and both.
// RULE5 - with internal generation on the generated vertical sync is output.
// RULE6 - with generation off, horizontal code 00 gives plain input and 01 the 2fH version.
// RULE7 - with generation off and the upper horizontal bit set the clamp-derived signal is output.
// RULE8 - with internal generation on the generated horizontal sync is output.
// RULE9 - one bit chooses generated or input-derived sync as the output source.
// RULE10 - the window bit maps timer a (0) or timer b (1) into indices fff0 to fff5.
// RULE11 - the input sync mode picks the horizontal and vertical input sources.
module ssrs_top (
    input  wire logic                      clock,
    input  wire logic                      resetn,
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [ssrs_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic [31:0]               wb_dat_i,
    output logic      [31:0]               wb_dat_o,
    output logic                           wb_ack_o,
    input  wire ssrs_pkg::ssrs_pins_t      pins,
    input  wire ssrs_pkg::ssrs_onchip_t    onchip,
    input  wire logic [15:0]               periph_adr,
    input  wire logic                      periph_stb,
    output logic                           timer_a_cs,
    output logic                           timer_b_cs,
    output logic                           horiz_sync_out,
    output logic                           vert_sync_out,
    output logic                           clamp_out
);
    ////////////////////////////////////////////////////////////////////////////
    // register bus
    logic [7:0]  sel_r, sel_nxt;
    logic [1:0]  mode_r, mode_nxt;
    logic        ack_nxt;
    logic [31:0] dat_nxt;
    logic [15:0] idx;
    logic        req;

    assign idx = wb_adr_i[ssrs_pkg::ADR_W-1:2];
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_comb begin
        sel_nxt  = sel_r;
        mode_nxt = mode_r;
        ack_nxt  = req;
        dat_nxt  = 32'h0000_0000;
        if (req) begin
            // unmapped indices are acked and read as zero
            if (idx == ssrs_pkg::IDX_SEL) begin
                dat_nxt = {24'h00_0000, sel_r};
                if (wb_we_i && wb_sel_i[0]) begin
                    sel_nxt = wb_dat_i[7:0]; // RULE1
                end
            end else if (idx == ssrs_pkg::IDX_MODE) begin
                dat_nxt = {24'h00_0000, mode_r, 6'h00};
                if (wb_we_i && wb_sel_i[0]) begin
                    mode_nxt = wb_dat_i[ssrs_pkg::MODE_LO+:2];
                end
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sel_r    <= ssrs_pkg::SEL_RESET; // RULE1
            mode_r   <= ssrs_pkg::MODE_RESET;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            sel_r    <= sel_nxt;
            mode_r   <= mode_nxt;
            wb_ack_o <= ack_nxt;
            wb_dat_o <= dat_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // input selection
    ssrs_pkg::ssrs_pins_t pin_s;
    logic                 isgen;
    logic [1:0]           clamp_sel, vert_sel, horiz_sel;
    logic                 hsrc, vsrc;

    ssrs_sync2 #(
        .W ($bits(ssrs_pkg::ssrs_pins_t))
    ) u_pin_sync (
        .clock  (clock),
        .resetn (resetn),
        .d      (pins),
        .q      (pin_s)
    );

    assign isgen     = sel_r[ssrs_pkg::BIT_ISGEN];
    assign clamp_sel = sel_r[ssrs_pkg::CLAMP_LO+:2];
    assign vert_sel  = sel_r[ssrs_pkg::VERT_LO+:2];
    assign horiz_sel = sel_r[ssrs_pkg::HORIZ_LO+:2];

    always_comb begin
        case (ssrs_pkg::ssrs_smode_t'(mode_r)) // RULE11
            ssrs_pkg::SMODE_FEEDBACK: begin
                hsrc = pin_s.horiz_feedback_in;
                vsrc = pin_s.vert_feedback_in;
            end
            ssrs_pkg::SMODE_SONG: begin
                hsrc = pin_s.composite_sync_in;
                vsrc = pin_s.phase_detect_vert;
            end
            ssrs_pkg::SMODE_COMPOSITE: begin
                hsrc = pin_s.horiz_sync_in;
                vsrc = pin_s.phase_detect_vert;
            end
            ssrs_pkg::SMODE_SEPARATE: begin
                hsrc = pin_s.horiz_sync_in;
                vsrc = pin_s.vert_sync_in;
            end
            default: begin
                hsrc = 1'b0;
                vsrc = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // sync shaping and output routing
    logic hsrc_d_r, hsrc_d_nxt;
    logic v_al_r, v_al_nxt;
    logic v_fm_r, v_fm_nxt;
    logic v_fa_r, v_fa_nxt;
    logic hout_nxt, vout_nxt, clout_nxt, ta_nxt, tb_nxt;
    logic hsrc_rise, in_win;

    assign hsrc_rise = hsrc && !hsrc_d_r;
    assign in_win   = periph_adr >= ssrs_pkg::WIN_LO && periph_adr <= ssrs_pkg::WIN_HI;

    always_comb begin
        hsrc_d_nxt = hsrc;
        // alignment: vertical level is only taken at a horizontal rising edge
        v_al_nxt  = hsrc_rise ? vsrc : v_al_r; // RULE4
        // fall modification: rises with input, falls only on the timer strobe
        if (vsrc) begin
            v_fm_nxt = 1'b1; // RULE4
        end else if (onchip.fall_mod_strobe) begin
            v_fm_nxt = 1'b0;
        end else begin
            v_fm_nxt = v_fm_r;
        end
        v_fa_nxt = hsrc_rise ? v_fm_r : v_fa_r; // RULE4
        case (clamp_sel) // RULE2
            2'b00:   clout_nxt = onchip.clamp_wave_a;
            2'b01:   clout_nxt = onchip.clamp_wave_b;
            2'b10:   clout_nxt = onchip.clamp_wave_c;
            default: clout_nxt = onchip.clamp_wave_d;
        endcase
        if (isgen) begin
            vout_nxt = onchip.generated_vert_sync; // RULE5 RULE9
            hout_nxt = onchip.generated_horiz_sync; // RULE8 RULE9
        end else begin
            case (vert_sel) // RULE3
                2'b00:   vout_nxt = vsrc;
                2'b01:   vout_nxt = v_al_r;
                2'b10:   vout_nxt = v_fm_r;
                default: vout_nxt = v_fa_r;
            endcase
            case (horiz_sel)
                2'b00:   hout_nxt = hsrc; // RULE6
                2'b01:   hout_nxt = hsrc && !onchip.mask_2fh; // RULE6
                default: hout_nxt = onchip.clamp_derived_signal; // RULE7
            endcase
        end
        // chip selects registered, so timers see them one clock after the address
        ta_nxt = periph_stb && in_win && !sel_r[ssrs_pkg::BIT_TIMER_WIN]; // RULE10
        tb_nxt = periph_stb && in_win && sel_r[ssrs_pkg::BIT_TIMER_WIN]; // RULE10
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            hsrc_d_r       <= 1'b0;
            v_al_r         <= 1'b0;
            v_fm_r         <= 1'b0;
            v_fa_r         <= 1'b0;
            horiz_sync_out <= 1'b0;
            vert_sync_out  <= 1'b0;
            clamp_out      <= 1'b0;
            timer_a_cs     <= 1'b0;
            timer_b_cs     <= 1'b0;
        end else begin
            hsrc_d_r       <= hsrc_d_nxt;
            v_al_r         <= v_al_nxt;
            v_fm_r         <= v_fm_nxt;
            v_fa_r         <= v_fa_nxt;
            horiz_sync_out <= hout_nxt;
            vert_sync_out  <= vout_nxt;
            clamp_out      <= clout_nxt;
            timer_a_cs     <= ta_nxt;
            timer_b_cs     <= tb_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    chk_sel_write: assert property ( // RULE1
        (req && wb_we_i && wb_sel_i[0] && idx == ssrs_pkg::IDX_SEL)
        |=> wb_ack_o && sel_r == $past(wb_dat_i[7:0]))
        else $error("selection register write lost");
    chk_sel_read: assert property ( // RULE1
        (req && !wb_we_i && idx == ssrs_pkg::IDX_SEL)
        |=> wb_dat_o == {24'h00_0000, $past(sel_r)})
        else $error("selection register read wrong");
    chk_clamp_wave_d: assert property ( // RULE2
        (clamp_sel == 2'b11) |=> clamp_out == $past(onchip.clamp_wave_d))
        else $error("clamp code 11 not wave d");
    chk_clamp_wave_a: assert property ( // RULE2
        (clamp_sel == 2'b00) |=> clamp_out == $past(onchip.clamp_wave_a))
        else $error("clamp code 00 not wave a");
    chk_vert_plain: assert property ( // RULE3
        (!isgen && vert_sel == 2'b00) |=> vert_sync_out == $past(vsrc))
        else $error("plain vertical not routed");
    chk_fall_hold: assert property ( // RULE4
        (v_fm_r && !vsrc && !onchip.fall_mod_strobe) |=> v_fm_r)
        else $error("fall modified vertical fell without strobe");
    chk_align_hold: assert property ( // RULE4
        (!hsrc_rise && !isgen && vert_sel == 2'b01 && $stable(sel_r))
        |=> vert_sync_out == $past(vert_sync_out, 1) || $past(hsrc_rise, 2) || !$stable(sel_r))
        else $error("aligned vertical moved off horizontal edge");
    chk_vert_gen: assert property ( // RULE5
        isgen |=> vert_sync_out == $past(onchip.generated_vert_sync))
        else $error("generated vertical not routed");
    chk_horiz_2fh: assert property ( // RULE6
        (!isgen && horiz_sel == 2'b01 && onchip.mask_2fh) |=> !horiz_sync_out)
        else $error("2fH mask ignored");
    chk_horiz_clamp: assert property ( // RULE7
        (!isgen && horiz_sel[1]) |=> horiz_sync_out == $past(onchip.clamp_derived_signal))
        else $error("clamp derived signal not routed");
    chk_horiz_gen: assert property ( // RULE8 RULE9
        isgen |=> horiz_sync_out == $past(onchip.generated_horiz_sync))
        else $error("generated horizontal not routed");
    chk_win_timer_b: assert property ( // RULE10
        (periph_stb && in_win && sel_r[ssrs_pkg::BIT_TIMER_WIN]) |=> timer_b_cs && !timer_a_cs)
        else $error("timer b window decode wrong");
    chk_mode_sep: assert property ( // RULE11
        (mode_r == 2'b11) |-> vsrc == pin_s.vert_sync_in && hsrc == pin_s.horiz_sync_in)
        else $error("separate mode sources wrong");

    cov_isgen_on: cover property (req && wb_we_i && wb_dat_i[ssrs_pkg::BIT_ISGEN]);
    cov_timer_b: cover property (timer_b_cs);
    cov_fall_mod: cover property (v_fm_r && onchip.fall_mod_strobe && !vsrc);
endmodule

// file: verif/ssrs_video_src.sv
// source model for the sync pins and the on-chip sync and clamp sources
`timescale 1ns/1ps
module ssrs_video_src (
    input  wire logic                   clock,
    input  wire logic                   resetn,
    input  wire ssrs_pkg::ssrs_pins_t   pins_d,
    input  wire ssrs_pkg::ssrs_onchip_t onchip_d,
    output ssrs_pkg::ssrs_pins_t        pins,
    output ssrs_pkg::ssrs_onchip_t      onchip
);
    // sources only move just after an edge, as the real timer flops do
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pins   <= '0;
            onchip <= '0;
        end else begin
            pins   <= pins_d;
            onchip <= onchip_d;
        end
    end
endmodule

// file: verif/ssrs_top_tb.sv
// self-checking bench for the sync routing select block
`timescale 1ns/1ps
module ssrs_top_tb;
    logic                       clock, resetn, cyc, stb, we, ack, pstb, h_o, v_o, c_o, ta, tb;
    logic [ssrs_pkg::ADR_W-1:0] adr;
    logic [3:0]                 sel;
    logic [31:0]                dat, dout, rdat, rng;
    logic [15:0]                padr;
    logic [7:0]                 s;
    logic [1:0]                 m;
    logic                       inw;
    ssrs_pkg::ssrs_pins_t       pv, pq;
    ssrs_pkg::ssrs_onchip_t     ov, oq;
    int                         bad_count, checks;
    // vertical steps: skip, code, horizontal, vertical, fall strobe, expected
    localparam logic [6:0]  SEQ [19] = '{7'h22, 7'h25, 7'h21, 7'h22, 7'h50, 7'h18, 7'h14,
        7'h1d, 7'h19, 7'h11, 7'h18, 7'h72, 7'h3a, 7'h34, 7'h3d, 7'h31, 7'h39, 7'h33, 7'h3a};
    localparam logic [15:0] WADR [5] = '{16'hfff0, 16'hfff5, 16'hffef, 16'hfff6, 16'hfff3};

    ssrs_video_src SRC (.clock(clock), .resetn(resetn), .pins_d(pv), .onchip_d(ov),
        .pins(pq), .onchip(oq));
    ssrs_top DUT (.clock(clock), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dout),
        .wb_ack_o(ack), .pins(pq), .onchip(oq), .periph_adr(padr), .periph_stb(pstb),
        .timer_a_cs(ta), .timer_b_cs(tb), .horiz_sync_out(h_o), .vert_sync_out(v_o),
        .clamp_out(c_o));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [2:0] route(input logic [7:0] r, input logic [1:0] md,
        input ssrs_pkg::ssrs_pins_t p, input ssrs_pkg::ssrs_onchip_t o);
        logic       ih, iv, h;
        logic [3:0] cw;
        ih = (md == 2'h0) ? p.horiz_feedback_in :
             (md == 2'h1) ? p.composite_sync_in : p.horiz_sync_in;
        iv = (md == 2'h0) ? p.vert_feedback_in :
             (md == 2'h3) ? p.vert_sync_in : p.phase_detect_vert;
        h = r[7] ? o.clamp_derived_signal : (r[6] ? ih & ~o.mask_2fh : ih);
        cw = {o.clamp_wave_d, o.clamp_wave_c, o.clamp_wave_b, o.clamp_wave_a};
        if (r[ssrs_pkg::BIT_ISGEN])
            return {o.generated_horiz_sync, o.generated_vert_sync, cw[r[3:2]]};
        return {h, iv, cw[r[3:2]]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            bad_count++;
        end
    endtask

    // one classic cycle; holds everything until ack is seen at an edge
    task automatic wb(input logic w, input logic [15:0] idx, input logic [3:0] bs,
        input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= bs;
        dat <= {24'h0, d};
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rdat = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50)
            chk(32'h0, 32'h1);
    endtask

    task automatic finish_test();
        if (bad_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        finish_test();
    end

    initial begin
        {resetn, cyc, stb, we, adr, sel, dat, pstb, padr, pv, ov} = '0;
        rng = 32'hb31b;
        bad_count = 0;
        checks = 0;
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        wb(1'b0, ssrs_pkg::IDX_SEL, 4'hf, 8'h00);
        chk(rdat, {24'h0, ssrs_pkg::SEL_RESET});
        wb(1'b0, ssrs_pkg::IDX_MODE, 4'hf, 8'h00);
        chk(rdat, 32'h0);
        // unmapped place and a write without lane 0 must both leave the register alone
        wb(1'b1, 16'h1234, 4'hf, 8'hff);
        wb(1'b0, 16'h1234, 4'hf, 8'h00);
        chk(rdat, 32'h0);
        wb(1'b1, ssrs_pkg::IDX_SEL, 4'he, 8'h5a);
        wb(1'b0, ssrs_pkg::IDX_SEL, 4'hf, 8'h00);
        chk(rdat, 32'h0);
        for (int i = 0; i < 40; i++) begin
            rng = xs(rng);
            s = (i < 4) ? {i[1:0], 2'h0, i[1:0], 2'h0} : rng[7:0] & 8'hcf;
            m = (i < 4) ? i[1:0] : rng[9:8];
            wb(1'b1, ssrs_pkg::IDX_SEL, 4'h1, s);
            wb(1'b1, ssrs_pkg::IDX_MODE, 4'h1, {m, 6'h0});
            wb(1'b0, ssrs_pkg::IDX_SEL, 4'hf, 8'h00);
            chk(rdat, {24'h0, s});
            pv <= rng[15:10];
            ov <= rng[24:16];
            repeat (8) @(posedge clock);
            chk({h_o, v_o, c_o}, route(s, m, pv, ov));
        end
        wb(1'b1, ssrs_pkg::IDX_MODE, 4'h1, 8'hc0);
        pv <= '0;
        ov <= '0;
        foreach (SEQ[k]) begin
            wb(1'b1, ssrs_pkg::IDX_SEL, 4'h1, {2'h0, SEQ[k][5:4], 4'h0});
            pv.horiz_sync_in <= SEQ[k][3];
            pv.vert_sync_in <= SEQ[k][2];
            ov.fall_mod_strobe <= SEQ[k][1];
            repeat (8) @(posedge clock);
            if (!SEQ[k][6])
                chk(v_o, SEQ[k][0]);
        end
        foreach (WADR[j]) begin
            for (int b = 0; b < 2; b++) begin
                wb(1'b1, ssrs_pkg::IDX_SEL, 4'h1, {7'h0, b[0]});
                inw = WADR[j] >= ssrs_pkg::WIN_LO && WADR[j] <= ssrs_pkg::WIN_HI;
                pstb <= 1'b1;
                padr <= WADR[j];
                @(posedge clock);
                pstb <= 1'b0;
                @(posedge clock);
                chk({ta, tb}, {inw & ~b[0], inw & b[0]});
                @(posedge clock);
                chk({ta, tb}, 32'h0);
            end
        end
        finish_test();
    end
endmodule
